//--- testbench/ppc_board_model.sv
// Board side of the pins: device drive, board drive, pull-ups
`timescale 1ns/100ps
module ppc_board_model
  import ppc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PPC_NPIN-1:0] pin_out_i,
  input wire logic [PPC_NPIN-1:0] pin_oe_n_i,
  input wire logic [PPC_NPIN-1:0] pin_pullup_en_i,
  input wire logic [PPC_NPIN-1:0] board_en_i,
  input wire logic [PPC_NPIN-1:0] board_val_i,
  output logic [PPC_NPIN-1:0] pin_level_o
);
  // ****
  // Pin resolution
  // ****
  logic flt_q = 1'b0;  // Undriven lines wander, so stale values never pass
  always_ff @(posedge clk_i) begin
    flt_q <= ~flt_q;
  end
  // Device wins, then board, then weak pull-up
  assign pin_level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & board_en_i & board_val_i)
    | (pin_oe_n_i & ~board_en_i & (pin_pullup_en_i | {PPC_NPIN{flt_q}}));
endmodule

//--- testbench/ppc_crossbar_sva.sv
// Port checks for the priority port crossbar
`timescale 1ns/100ps
module ppc_crossbar_sva
  import ppc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [1:0] slave_select_mode_i,
  input wire logic [PPC_NSLOT-1:0] fn_out_i,
  input wire logic [PPC_NSLOT-1:0] fn_drive_i,
  input wire logic [PPC_NSLOT-1:0] fn_in_o,
  input wire logic [PPC_NPIN-1:0] pin_in_i,
  input wire logic [PPC_NPIN-1:0] pin_out_o,
  input wire logic [PPC_NPIN-1:0] pin_oe_n_o,
  input wire logic [PPC_NPIN-1:0] pin_pullup_en_o,
  input wire logic [PPC_NPIN-1:0] pin_rx_en_o
);
  // ****
  // Route register shadow
  // ****
  logic [7:0] r0_q;  // Last route0 write
  logic [7:0] r1_q;  // Last route1 write
  logic [1:0] age_q;  // Edges since any write, saturates so pins have settled
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow follows writes only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r0_q <= 8'h00;
      r1_q <= 8'h00;
      age_q <= 2'h0;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == PPC_ROUTE0_ADDR) r0_q <= sfr_wdata_i;
      if (sfr_addr_i == PPC_ROUTE1_ADDR) r1_q <= sfr_wdata_i;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // ****
  // Assertions
  // ****
  a_serial_tx_fixed: assert property (r0_q[0] && r1_q[6] && age_q == 2'h3
    |-> pin_out_o[4] == $past(fn_out_i[0])) else $error("serial transmit pin not following source");
  a_rx_after_rst: assert property ($fell(sys_rst_i) |-> ##[1:3] pin_rx_en_o == '1)
    else $error("receivers not on after reset");
  a_analog_all_off: assert property ((~pin_rx_en_o & (~pin_oe_n_o | pin_pullup_en_o)) == '0)
    else $error("analog pin still driven or pulled");
  a_pud_all_off: assert property (r1_q[7] && age_q == 2'h3 |-> pin_pullup_en_o == '0)
    else $error("pull-up on while disabled");
  a_pullup_low_off: assert property ((pin_pullup_en_o & ~pin_oe_n_o & ~pin_out_o) == '0)
    else $error("pull-up on a pin driving low");
  a_xbar_off_hiz: assert property (!r1_q[6] && age_q == 2'h3 |-> pin_oe_n_o == '1)
    else $error("driver on with crossbar off");
  a_route2_upper: assert property (sfr_rd_i && sfr_addr_i == PPC_ROUTE2_ADDR
    |=> sfr_rdata_o[7:1] == 7'h00) else $error("route2 upper bits not zero");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> pin_oe_n_o == '1
    && pin_pullup_en_o == '0 && fn_in_o == '1) else $error("outputs not at reset values");
endmodule
bind ppc_crossbar ppc_crossbar_sva i_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .slave_select_mode_i(slave_select_mode_i), .fn_out_i(fn_out_i), .fn_drive_i(fn_drive_i),
  .fn_in_o(fn_in_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
  .pin_pullup_en_o(pin_pullup_en_o), .pin_rx_en_o(pin_rx_en_o));

//--- testbench/ppc_crossbar_tb_top.sv
// Self-checking bench for the priority port crossbar
`timescale 1ns/100ps
module ppc_crossbar_tb_top;
  import ppc_pkg::*;
  // ****
  // Stimulus and observed signals
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] ss_mode = 2'h0;
  logic [PPC_NSLOT-1:0] fo = '0;
  logic [PPC_NSLOT-1:0] fd = 23'h23fffd;  // Input-only slots never drive
  logic [PPC_NSLOT-1:0] fi;
  logic [31:0] lvl, po, poe, ppu, prx;
  logic [31:0] b_en = '0;
  logic [31:0] b_val = '0;
  int err_total = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  ppc_crossbar i_dut (.clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .slave_select_mode_i(ss_mode), .fn_out_i(fo),
    .fn_drive_i(fd), .fn_in_o(fi), .pin_in_i(lvl), .pin_out_o(po), .pin_oe_n_o(poe),
    .pin_pullup_en_o(ppu), .pin_rx_en_o(prx));
  ppc_board_model i_board (.clk_i(clk), .pin_out_i(po), .pin_oe_n_i(poe), .pin_pullup_en_i(ppu),
    .board_en_i(b_en), .board_val_i(b_val), .pin_level_o(lvl));
  // ****
  // Shared tasks
  // ****
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    check(what, 32'(rdata), 32'(exp));
  endtask
  // Map, output and input syncs all need a few edges
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd_chk("route0", PPC_ROUTE0_ADDR, 8'h00);
    rd_chk("route1", PPC_ROUTE1_ADDR, 8'h00);
    rd_chk("mdin", PPC_MDIN_ADDR[0], 8'hff);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_reg(PPC_ROUTE2_ADDR, 8'hff);
    rd_chk("route2", PPC_ROUTE2_ADDR, 8'h01);
    wr_reg(PPC_ROUTE2_ADDR, 8'h00);
    check("rx_en", prx, '1);
    $display("Test regs done");
  endtask
  // Serial0, SPI, SMBus with P0.0 skipped; order modes, skips, routes, enable
  task automatic t_prio;
    wr_reg(PPC_MDOUT_ADDR[0], 8'hff);
    wr_reg(PPC_SKIP_ADDR[0], 8'h01);
    wr_reg(PPC_ROUTE0_ADDR, 8'h07);
    wr_reg(PPC_ROUTE1_ADDR, 8'h40);
    b_en = 32'h20;
    for (int v = 0; v < 2; v++) begin
      fo = v ? 23'h2a : 23'h55;
      b_val = v ? 32'h20 : 32'h0;
      settle;
      check("prio pins", po & 32'hdf, {24'h0, fo[7:6], 1'b0, fo[0], fo[4:2], 1'b1});
      check("sda od", 32'({poe[6], ppu[6]}), 32'({fo[6], fo[6]}));
      check("pp drive", 32'(poe[3:1]), 32'h0);
      check("serial0 rx in", 32'(fi[1]), v);
    end
    ss_mode = 2'h1;
    fo = 23'h20;
    settle;
    check("ssel pin", 32'(po[8:6]), 32'h1);
    ss_mode = 2'h0;
    b_en = '0;
    wr_reg(PPC_ROUTE0_ADDR, 8'h00);
    wr_reg(PPC_SKIP_ADDR[0], 8'h00);
    wr_reg(PPC_MDOUT_ADDR[0], 8'h00);
    $display("Test prio done");
  endtask
  task automatic t_cnt;
    fo = '0;
    for (int c = 0; c < 8; c++) begin
      wr_reg(PPC_ROUTE1_ADDR, 8'h40 | 8'(c));
      settle;
      check("counter pins", po & 32'h1f, (c < 6) ? 32'h1f & ~((32'h1 << c) - 1) : 32'h1f);
    end
    $display("Test counter done");
  endtask
  task automatic t_single;
    logic [4:0] slot [5] = '{5'h0c, 5'h08, 5'h09, 5'h0a, 5'h0b};
    wr_reg(PPC_ROUTE1_ADDR, 8'h40);
    for (int b = 3; b < 8; b++) begin
      wr_reg(PPC_ROUTE0_ADDR, 8'h01 << b);
      fo = '1;
      fo[slot[b-3]] = 1'b0;
      settle;
      check("single fn", 32'(po[1:0]), 32'h2);
    end
    wr_reg(PPC_ROUTE0_ADDR, 8'h00);
    b_en = 32'h3;
    b_val = '0;
    for (int b = 3; b < 6; b++) begin
      wr_reg(PPC_ROUTE1_ADDR, 8'h40 | (8'h01 << b));
      settle;
      check("timer in", 32'(fi[20:18]), 32'(3'(~(3'h1 << (b - 3)))));
    end
    wr_reg(PPC_ROUTE1_ADDR, 8'h40);
    wr_reg(PPC_ROUTE2_ADDR, 8'h01);
    fo = '0;
    settle;
    check("serial1", 32'({po[0], fi[22]}), 32'h0);
    wr_reg(PPC_ROUTE2_ADDR, 8'h00);
    $display("Test single done");
  endtask
  task automatic t_drive;
    wr_reg(PPC_LATCH_ADDR[1], 8'h0f);
    settle;
    // Latch ones release (open-drain), latch zeros pull low
    check("od drive", 32'(poe[15:8]), 32'h0f);
    check("od pull", 32'(ppu[15:8]), 32'h0f);
    wr_reg(PPC_MDIN_ADDR[2], 8'h00);
    settle;
    check("analog rx", 32'(prx[23:16]), 32'h0);
    rd_chk("analog rd", PPC_LATCH_ADDR[2], 8'h00);
    b_en = 32'hff000000;
    b_val = 32'h5a000000;
    settle;
    rd_chk("pin rd", PPC_LATCH_ADDR[3], 8'h5a);
    wr_reg(PPC_ROUTE1_ADDR, 8'hc0);
    settle;
    check("pud", ppu, '0);
    wr_reg(PPC_ROUTE1_ADDR, 8'h00);
    settle;
    check("xbar off", poe, '1);
    $display("Test drive done");
  endtask
  // ****
  // Sequence and watchdog
  // ****
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_prio;
    t_cnt;
    t_single;
    t_drive;
    finish_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    err_total++;
    finish_test;
  end
endmodule

//--- verilog/ppc_allocator.sv
// Priority allocation of function slots onto crossbar pins
`timescale 1ns/100ps
module ppc_allocator
  import ppc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  ppc_cfg_if.alloc cfg
);

  // ****************************************
  // Allocation
  // ****************************************
  logic [PPC_NSLOT-1:0] en;  // Slots asking for a pin
  logic [PPC_NPIN-1:0] occ;  // Pins taken or skipped
  logic [PPC_NPIN-1:0] used_d;
  logic [PPC_NPIN-1:0] used_q;
  logic [PPC_SLOT_W-1:0] slot_d [PPC_NPIN];
  logic [PPC_SLOT_W-1:0] slot_q [PPC_NPIN];
  logic found;

  assign en = ppc_slot_enables(cfg.route0, cfg.route1, cfg.route2, cfg.ss_mode);

  // Walk slots in priority order, each taking the lowest free pin
  always_comb begin
    occ = cfg.skip;
    used_d = '0;
    found = 1'b0;
    for (int p = 0; p < PPC_NPIN; p++) begin
      slot_d[p] = '0;
    end
    // Fixed pins win even over skip bits
    if (en[PPC_S_SER0_TX]) begin
      occ[PPC_SER0_TX_PIN] = 1'b1;
      occ[PPC_SER0_RX_PIN] = 1'b1;
      used_d[PPC_SER0_TX_PIN] = 1'b1;
      used_d[PPC_SER0_RX_PIN] = 1'b1;
      slot_d[PPC_SER0_TX_PIN] = PPC_S_SER0_TX;
      slot_d[PPC_SER0_RX_PIN] = PPC_S_SER0_RX;
    end
    for (int s = PPC_S_SCK; s < PPC_NSLOT; s++) begin
      found = 1'b0;
      if (en[s]) begin
        // Pairs fall on consecutive free pins by order alone
        for (int p = 0; p < PPC_NPIN; p++) begin
          if (!found && !occ[p]) begin
            occ[p] = 1'b1;
            used_d[p] = 1'b1;
            slot_d[p] = PPC_SLOT_W'(s);
            found = 1'b1;
          end
        end
      end
    end
  end

  // Map is refreshed every cycle; slots with no free pin drop out
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      used_q <= '0;
      for (int p = 0; p < PPC_NPIN; p++) begin
        slot_q[p] <= '0;
      end
    end else begin
      used_q <= used_d;
      slot_q <= slot_d;
    end
  end

  assign cfg.pin_used = used_q;
  assign cfg.pin_slot = slot_q;

endmodule

//--- verilog/ppc_cfg_if.sv
// Configuration and pin map carried between the crossbar's own modules
`timescale 1ns/100ps
interface ppc_cfg_if;
  import ppc_pkg::*;
  logic [7:0] route0;  // Function enables, first register
  logic [7:0] route1;  // Enables, pull-up and crossbar enable
  logic [7:0] route2;  // Secondary serial enable
  logic [PPC_NPIN-1:0] skip;  // Pins left out of allocation
  logic [PPC_NPIN-1:0] mdin;  // 1 digital, 0 analog
  logic [PPC_NPIN-1:0] mdout;  // 1 push-pull, 0 open-drain
  logic [PPC_NPIN-1:0] latch;  // Port output latches
  logic [PPC_NPIN-1:0] pin_level;  // Synchronised pin levels
  logic [1:0] ss_mode;  // Slave-select mode from SPI
  logic [PPC_NPIN-1:0] pin_used;  // Pin carries a function
  logic [PPC_SLOT_W-1:0] pin_slot [PPC_NPIN];  // Function on each pin

  modport regs(output route0, route1, route2, skip, mdin, mdout, latch, input pin_level);
  modport alloc(input route0, route1, route2, skip, ss_mode, output pin_used, pin_slot);
  modport core(input route1, mdin, mdout, latch, pin_used, pin_slot, output pin_level, ss_mode);
endinterface

//--- verilog/ppc_crossbar.sv
// Top of the priority port crossbar: pin cells for ports 0 to 3
//
// Notes on behaviour
// - Enabled functions take lowest free pin, priority order
// - Taken and skipped pins are passed over
// - Primary serial fixed on P0.4 and P0.5
// - SMBus and serial ports take pin pairs
// - Only P0.0 to P3.7 join allocation
// - Leftover pins stay ordinary port pins
// - Slave select routed only in four-wire mode
// - Latch read returns actual pin level; analog pins read zero
// - Input mode one digital; reset all digital
// - Analog pin: pull-up, driver, receiver off
// - Drive mode per pin; SMBus always open-drain
// - Pull-up disable bit; open-drain pins only
// - No pull-up while pin drives low
// - Crossbar off keeps all drivers off
// - First route register bit assignments
// - Timer and counter input enable bits
// - Counter module field cumulative; high codes reserved
// - Third register bit zero routes second serial
// - Skip one excludes pin; mode one push-pull
`timescale 1ns/100ps
module ppc_crossbar
  import ppc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [1:0] slave_select_mode_i,
  input wire logic [PPC_NSLOT-1:0] fn_out_i,
  input wire logic [PPC_NSLOT-1:0] fn_drive_i,
  output logic [PPC_NSLOT-1:0] fn_in_o,
  input wire logic [PPC_NPIN-1:0] pin_in_i,
  output logic [PPC_NPIN-1:0] pin_out_o,
  output logic [PPC_NPIN-1:0] pin_oe_n_o,
  output logic [PPC_NPIN-1:0] pin_pullup_en_o,
  output logic [PPC_NPIN-1:0] pin_rx_en_o
);

  // ****************************************
  // Shared configuration
  // ****************************************
  ppc_cfg_if cfg ();

  // Register file; read data flop drives the port directly
  ppc_sfr_regs u_regs (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o),
    .cfg(cfg)
  );

  // Pin allocator, registered map
  ppc_allocator u_alloc (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cfg(cfg)
  );

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  logic [PPC_NPIN-1:0] pin_meta_q;  // First stage, read only by next
  logic [PPC_NPIN-1:0] pin_sync_q;  // Safe pin levels

  // Pins are asynchronous; two stages before any use
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= pin_in_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign cfg.pin_level = pin_sync_q;
  assign cfg.ss_mode = slave_select_mode_i;

  // ****************************************
  // Global controls
  // ****************************************
  logic xbar_on;  // Crossbar enable
  logic pud;  // Pull-up disable

  assign xbar_on = cfg.route1[PPC_XBAR_EN_BIT];
  assign pud = cfg.route1[PPC_PUD_BIT];

  // ****************************************
  // Pin cells
  // ****************************************
  logic [PPC_NPIN-1:0] out_d;
  logic [PPC_NPIN-1:0] oe_n_d;
  logic [PPC_NPIN-1:0] pu_d;
  logic [PPC_NPIN-1:0] rx_d;

  for (genvar p = 0; p < PPC_NPIN; p++) begin : g_pin
    logic [PPC_SLOT_W-1:0] sl;  // Function on this pin
    logic routed;  // Pin given to a function
    logic sel_out;  // Level the pin would show
    logic sel_drv;  // Source wants to drive
    logic is_smb;  // SMBus data or clock
    logic digital;  // Digital input mode
    logic open_drain;  // Effective drive mode
    logic drive;  // Driver actually on
    assign sl = cfg.pin_slot[p];
    assign routed = cfg.pin_used[p];
    // Unrouted pins fall back to their latch
    assign sel_out = routed ? fn_out_i[sl] : cfg.latch[p];
    assign sel_drv = routed ? fn_drive_i[sl] : 1'b1;
    assign is_smb = routed & ((sl == PPC_S_SDA) | (sl == PPC_S_SCL));
    assign digital = cfg.mdin[p];
    assign open_drain = ~cfg.mdout[p] | is_smb;
    // Open-drain drives only lows; a high is released
    assign drive = xbar_on & digital & sel_drv & (~open_drain | ~sel_out);
    assign out_d[p] = sel_out;
    assign oe_n_d[p] = ~drive;
    // Pull-up off on analog, push-pull and driven-low pins
    assign pu_d[p] = ~pud & digital & open_drain & ~drive;
    assign rx_d[p] = digital;
  end

  // ****************************************
  // Function inputs
  // ****************************************
  logic [PPC_NSLOT-1:0] fn_in_d;

  // Unrouted functions see an idle high; analog pins read low
  always_comb begin
    fn_in_d = '1;
    for (int p = 0; p < PPC_NPIN; p++) begin
      if (cfg.pin_used[p]) begin
        fn_in_d[cfg.pin_slot[p]] = pin_sync_q[p] & cfg.mdin[p];
      end
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // All pins released during reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_out_o <= '1;
      pin_oe_n_o <= '1;
      pin_pullup_en_o <= '0;
      pin_rx_en_o <= '0;
      fn_in_o <= '1;
    end else begin
      pin_out_o <= out_d;
      pin_oe_n_o <= oe_n_d;
      pin_pullup_en_o <= pu_d;
      pin_rx_en_o <= rx_d;
      fn_in_o <= fn_in_d;
    end
  end

endmodule

//--- verilog/ppc_pkg.sv
// Shared constants, register map and slot decoding for the priority port crossbar
package ppc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int PPC_NPIN = 32;  // Pins P0.0 to P3.7
  localparam int PPC_NPORT = 4;  // Ports 0 to 3
  localparam int PPC_NSLOT = 23;  // Routable function signals
  localparam int PPC_SLOT_W = 5;  // Width of a slot number

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] PPC_ROUTE0_ADDR = 8'he1;
  localparam logic [7:0] PPC_ROUTE1_ADDR = 8'he2;
  localparam logic [7:0] PPC_ROUTE2_ADDR = 8'he3;
  localparam logic [7:0] PPC_LATCH_ADDR [PPC_NPORT] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
  localparam logic [7:0] PPC_MDIN_ADDR [PPC_NPORT] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4};
  localparam logic [7:0] PPC_MDOUT_ADDR [PPC_NPORT] = '{8'ha4, 8'ha5, 8'ha6, 8'ha7};
  localparam logic [7:0] PPC_SKIP_ADDR [PPC_NPORT] = '{8'hd4, 8'hd5, 8'hd6, 8'hd7};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PPC_ROUTE_RST = 8'h00;
  localparam logic [7:0] PPC_LATCH_RST = 8'hff;
  localparam logic [7:0] PPC_MDIN_RST = 8'hff;  // Digital inputs
  localparam logic [7:0] PPC_MDOUT_RST = 8'h00;
  localparam logic [7:0] PPC_SKIP_RST = 8'h00;
  localparam logic [7:0] PPC_ROUTE2_MASK = 8'h01;  // Upper bits reserved

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PPC_SERIAL0_BIT = 0;
  localparam int PPC_SPI_BIT = 1;
  localparam int PPC_SMBUS_BIT = 2;
  localparam int PPC_SYSCLK_BIT = 3;
  localparam int PPC_CMP0_BIT = 4;
  localparam int PPC_CMP0A_BIT = 5;
  localparam int PPC_CMP1_BIT = 6;
  localparam int PPC_CMP1A_BIT = 7;
  localparam int PPC_PUD_BIT = 7;
  localparam int PPC_XBAR_EN_BIT = 6;
  localparam int PPC_T1_BIT = 5;
  localparam int PPC_T0_BIT = 4;
  localparam int PPC_CNT_EXT_BIT = 3;
  localparam int PPC_CNT_LSB = 0;
  localparam int PPC_CNT_W = 3;
  localparam logic [2:0] PPC_CNT_MAX = 3'h5;  // Higher codes reserved
  localparam int PPC_SERIAL1_BIT = 0;
  localparam logic [1:0] PPC_SS_3WIRE = 2'h0;
  localparam int PPC_SER0_TX_PIN = 4;
  localparam int PPC_SER0_RX_PIN = 5;

  // ****************************************
  // Slot numbers in priority order
  // ****************************************
  localparam logic [4:0] PPC_S_SER0_TX = 5'h00;
  localparam logic [4:0] PPC_S_SER0_RX = 5'h01;
  localparam logic [4:0] PPC_S_SCK = 5'h02;
  localparam logic [4:0] PPC_S_SSEL = 5'h05;
  localparam logic [4:0] PPC_S_SDA = 5'h06;
  localparam logic [4:0] PPC_S_SCL = 5'h07;
  localparam logic [4:0] PPC_S_CNT0 = 5'h0d;
  localparam logic [4:0] PPC_S_TX1 = 5'h15;

  // Which slots ask for a pin
  function automatic logic [PPC_NSLOT-1:0] ppc_slot_enables(input logic [7:0] r0, input logic [7:0] r1,
                                                          input logic [7:0] r2, input logic [1:0] ss);
    logic [PPC_NSLOT-1:0] en;
    logic [2:0] cnt;
    en = '0;
    cnt = r1[PPC_CNT_LSB +: PPC_CNT_W];
    en[1:0] = {2{r0[PPC_SERIAL0_BIT]}};
    en[4:2] = {3{r0[PPC_SPI_BIT]}};
    en[5] = r0[PPC_SPI_BIT] & (ss != PPC_SS_3WIRE);
    en[7:6] = {2{r0[PPC_SMBUS_BIT]}};
    en[8] = r0[PPC_CMP0_BIT];
    en[9] = r0[PPC_CMP0A_BIT];
    en[10] = r0[PPC_CMP1_BIT];
    en[11] = r0[PPC_CMP1A_BIT];
    en[12] = r0[PPC_SYSCLK_BIT];
    for (int k = 0; k < 5; k++) begin
      en[13+k] = (cnt <= PPC_CNT_MAX) && (cnt > 3'(k));
    end
    en[18] = r1[PPC_CNT_EXT_BIT];
    en[19] = r1[PPC_T0_BIT];
    en[20] = r1[PPC_T1_BIT];
    en[22:21] = {2{r2[PPC_SERIAL1_BIT]}};
    return en;
  endfunction

endpackage

//--- verilog/ppc_sfr_regs.sv
// Special function registers of the crossbar and ports 0 to 3
`timescale 1ns/100ps
module ppc_sfr_regs
  import ppc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  ppc_cfg_if.regs cfg
);

  // ****************************************
  // Crossbar registers
  // ****************************************
  logic [7:0] route0_q;
  logic [7:0] route1_q;
  logic [7:0] route2_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      route0_q <= PPC_ROUTE_RST;
      route1_q <= PPC_ROUTE_RST;
      route2_q <= PPC_ROUTE_RST;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == PPC_ROUTE0_ADDR) route0_q <= sfr_wdata_i;
      if (sfr_addr_i == PPC_ROUTE1_ADDR) route1_q <= sfr_wdata_i;
      if (sfr_addr_i == PPC_ROUTE2_ADDR) route2_q <= sfr_wdata_i & PPC_ROUTE2_MASK;
    end
  end

  // ****************************************
  // Per-port registers
  // ****************************************
  for (genvar g = 0; g < PPC_NPORT; g++) begin : g_port
    logic [7:0] latch_q;
    logic [7:0] mdin_q;
    logic [7:0] mdout_q;
    logic [7:0] skip_q;
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        latch_q <= PPC_LATCH_RST;
        mdin_q <= PPC_MDIN_RST;
        mdout_q <= PPC_MDOUT_RST;
        skip_q <= PPC_SKIP_RST;
      end else if (sfr_wr_i) begin
        if (sfr_addr_i == PPC_LATCH_ADDR[g]) latch_q <= sfr_wdata_i;
        if (sfr_addr_i == PPC_MDIN_ADDR[g]) mdin_q <= sfr_wdata_i;
        if (sfr_addr_i == PPC_MDOUT_ADDR[g]) mdout_q <= sfr_wdata_i;
        if (sfr_addr_i == PPC_SKIP_ADDR[g]) skip_q <= sfr_wdata_i;
      end
    end
    assign cfg.latch[8*g +: 8] = latch_q;
    assign cfg.mdin[8*g +: 8] = mdin_q;
    assign cfg.mdout[8*g +: 8] = mdout_q;
    assign cfg.skip[8*g +: 8] = skip_q;
  end

  // ****************************************
  // Read path
  // ****************************************
  // Latch reads show the pin, analog pins read zero
  always_comb begin
    rdata_d = 8'h00;  // Unmapped reads zero
    if (sfr_addr_i == PPC_ROUTE0_ADDR) rdata_d = route0_q;
    if (sfr_addr_i == PPC_ROUTE1_ADDR) rdata_d = route1_q;
    if (sfr_addr_i == PPC_ROUTE2_ADDR) rdata_d = route2_q;
    for (int g = 0; g < PPC_NPORT; g++) begin
      if (sfr_addr_i == PPC_LATCH_ADDR[g]) rdata_d = cfg.pin_level[8*g +: 8] & cfg.mdin[8*g +: 8];
      if (sfr_addr_i == PPC_MDIN_ADDR[g]) rdata_d = cfg.mdin[8*g +: 8];
      if (sfr_addr_i == PPC_MDOUT_ADDR[g]) rdata_d = cfg.mdout[8*g +: 8];
      if (sfr_addr_i == PPC_SKIP_ADDR[g]) rdata_d = cfg.skip[8*g +: 8];
    end
  end

  // Read data held until the next read strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign cfg.route0 = route0_q;
  assign cfg.route1 = route1_q;
  assign cfg.route2 = route2_q;

endmodule
